// ---- logic/atpg_gen.sv ----
// Converter and serial-interface test pattern generator with output buffer
`timescale 1ns/1ps
// Notes on behaviour
// - Nonzero converter code replaces samples with pattern
// - Either PN reset bit reseeds converter PN generators
// - Patterns ignore input; advance only per sample
// - Checkerboard alternates 0x1555 and 0x2AAA
// - Word toggle alternates zeros, ones, zeros first
// - Long PN x23+x18+1 seeded 0x3AFF
// - Short PN x9+x5+1 seeded 0x0092
// - User words cycle, or once then zeros
// - Two-bit field picks injection point
// - Code 01 injects ten-bit physical words
// - Code 10 injects one octet per word
// - Writing 0x81 soft resets, bit self clears
// - Transport test emits raw converter samples
// - Interface codes: off, checkerboard, word toggle
// - Interface codes 3-7 are seeded PN sequences
// - Interface ramp wraps at injection width
// - Code 1110 repeats four user words
// - Code 1111 sends user words once, zeros
module atpg_gen (
  input wire logic clk,
  input wire logic rstn,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [13:0] adc_sample,
  input wire logic adc_valid,
  output logic adc_ready,
  output logic [1:0] out_point,
  output logic [15:0] out_word,
  output logic out_valid,
  input wire logic out_ready
);
  import atpg_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] conv_sel; // Converter pattern select
    logic [7:0] tl_ctrl; // Transport sample test control
    logic [7:0] if_ctrl; // Interface pattern control
    logic [7:0] dl_ctrl; // Link layer test control, stored only
    logic [63:0] user; // Eight user pattern bytes
    logic [22:0] cpn_l; // Converter long PN state
    logic [8:0] cpn_s; // Converter short PN state
    logic ctog; // Converter alternation phase
    logic [13:0] cramp; // Converter ramp
    logic [1:0] cuix; // Converter user word index
    logic cudone; // Converter single pass finished
    logic [30:0] ipn; // Interface PN state
    logic [3:0] icode; // Interface code last seen
    logic itog; // Interface alternation phase
    logic [15:0] iramp; // Interface ramp
    logic [1:0] iuix; // Interface user word index
    logic iudone; // Interface single pass finished
    logic [7:0] rdata; // Read data
  } atpg_state_s;

  // Reset image: converter PN generators sit at their seeds, interface PN state at zero
  localparam atpg_state_s ST_RESET = '{
    cpn_l: SEED_PN23[22:0], cpn_s: SEED_PN9[8:0], ipn: '0, default: '0};

  atpg_state_s st;
  atpg_state_s next_st;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Fibonacci LFSR advanced n bits; returns {fresh bits, new state}
  function automatic logic [46:0] pn_adv(input logic [30:0] s0, input int len,
                                         input int tap, input int n);
    logic [30:0] s;
    logic [15:0] o;
    logic nb;
    s = s0;
    o = '0;
    for (int i = 0; i < 16; i++) begin
      if (i < n) begin
        nb = s[len-1] ^ s[tap-1];
        s = {s[29:0], nb};
        o = {o[14:0], nb};
      end
    end
    return {o, s};
  endfunction

  // User word k is built from two consecutive bytes, low byte first
  function automatic logic [15:0] user_word(input logic [63:0] u, input logic [1:0] k);
    return u[{k, 4'h0} +: 16];
  endfunction

  // Register readback
  function automatic logic [7:0] reg_read(input atpg_state_s s, input logic [11:0] a);
    logic [7:0] r;
    r = '0;
    if (a == OFS_CONV_SEL) begin
      r = s.conv_sel;
    end else if (a >= OFS_USER_FIRST && a <= OFS_USER_LAST) begin
      r = s.user[{3'(a - OFS_USER_FIRST), 3'h0} +: 8];
    end else if (a == OFS_TL_CTRL) begin
      r = s.tl_ctrl;
    end else if (a == OFS_IF_CTRL) begin
      r = s.if_ctrl;
    end else if (a == OFS_DL_CTRL) begin
      r = s.dl_ctrl;
    end
    return r;
  endfunction

  // ----------------------------------------
  // Buffer between generator and link side
  // ----------------------------------------
  atpg_stream_if #(.W(OUT_W)) fin ();
  atpg_stream_if #(.W(OUT_W)) fout ();

  atpg_fifo #(.W(OUT_W), .D(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .wr(fin.snk),
    .rd(fout.src)
  );

  assign out_valid = fout.valid;
  assign {out_point, out_word} = fout.data;
  assign fout.ready = out_ready;
  assign adc_ready = fin.ready;
  assign reg_rdata = st.rdata;

  // ----------------------------------------
  // Converter pattern stage
  // ----------------------------------------
  logic [3:0] ccode;
  logic push;
  logic [46:0] pnl;
  logic [46:0] pns;
  logic [13:0] conv_word;
  logic [15:0] sample;

  assign ccode = st.conv_sel[3:0];
  // Generators only step when a sample is taken; the analog value is unused
  assign push = fin.valid && fin.ready;
  assign pnl = pn_adv({8'h0, st.cpn_l}, 23, 18, 14);
  assign pns = pn_adv({22'h0, st.cpn_s}, 9, 5, 14);

  // Pattern word chosen by the converter code
  always_comb begin
    case (ccode)
      CV_OFF: conv_word = adc_sample;
      CV_MID: conv_word = '0;
      CV_PFS: conv_word = W14_PFS;
      CV_NFS: conv_word = W14_NFS;
      CV_CHK: conv_word = st.ctog ? W14_CHK_B : W14_CHK_A;
      CV_PNL: conv_word = pnl[44:31];
      CV_PNS: conv_word = pns[44:31];
      CV_TOG: conv_word = st.ctog ? W14_ONES : '0;
      CV_USER: conv_word = st.cudone ? '0 : 14'(user_word(st.user, st.cuix) >> 2);
      CV_RAMP: conv_word = st.cramp;
      default: conv_word = '0; // Undefined codes still cut off the input
    endcase
  end

  // Transport sample test bypasses any converter pattern
  assign sample = st.tl_ctrl[BIT_TL_TEST] ? {adc_sample, 2'b00} : {conv_word, 2'b00};

  // ----------------------------------------
  // Interface pattern stage
  // ----------------------------------------
  logic [3:0] icode;
  logic [1:0] ipt;
  int iw;
  int ilen;
  int itap;
  logic [30:0] iseed;
  logic [15:0] imask;
  logic [46:0] ipn_nx;
  logic [15:0] iword;

  assign icode = st.if_ctrl[3:0];
  assign ipt = st.if_ctrl[5:4];

  // Word width per injection point, length and seed per PN code
  always_comb begin
    case (ipt)
      PT_PHY10: iw = 10;
      PT_SCR8: iw = 8;
      default: iw = 16;
    endcase
    case (icode)
      IF_PN31: begin
        ilen = 31;
        itap = 28;
        iseed = SEED_PN31;
      end
      IF_PN23: begin
        ilen = 23;
        itap = 18;
        iseed = SEED_PN23;
      end
      IF_PN15: begin
        ilen = 15;
        itap = 14;
        iseed = SEED_PN15;
      end
      IF_PN9: begin
        ilen = 9;
        itap = 5;
        iseed = SEED_PN9;
      end
      default: begin
        ilen = 7;
        itap = 6;
        iseed = SEED_PN7;
      end
    endcase
  end

  assign imask = 16'((17'h1 << iw) - 17'h1);
  assign ipn_nx = pn_adv(st.ipn, ilen, itap, iw);

  // Interface word, trimmed to the injection width for pattern codes; any other code gives the untrimmed sample
  always_comb begin
    case (icode)
      IF_CHK: iword = (st.itog ? W16_CHK_B : W16_CHK_A) & imask;
      IF_TOG: iword = (st.itog ? W16_ONES : '0) & imask;
      IF_PN31, IF_PN23, IF_PN15, IF_PN9, IF_PN7: iword = ipn_nx[46:31] & imask;
      IF_RAMP: iword = st.iramp & imask;
      IF_UREP: iword = user_word(st.user, st.iuix) >> (16 - iw);
      IF_USGL: iword = st.iudone ? '0 : user_word(st.user, st.iuix) >> (16 - iw);
      default: iword = sample;
    endcase
  end

  // Samples pass unless an interface pattern is active
  assign fin.valid = adc_valid;
  assign fin.data = (icode != IF_OFF) ? {ipt, iword} : {PT_SAMPLE, sample};

  // ----------------------------------------
  // Next state: registers, soft reset, generators
  // ----------------------------------------
  always_comb begin
    next_st = st;
    next_st.rdata = reg_rd ? reg_read(st, reg_addr) : st.rdata;
    // Converter generators step once per accepted sample
    if (push) begin
      next_st.ctog = ~st.ctog;
      next_st.cpn_l = pnl[22:0];
      next_st.cpn_s = pns[8:0];
      next_st.cramp = st.cramp + 14'h1;
      if (ccode == CV_USER && !st.cudone) begin
        next_st.cuix = st.cuix + 2'h1;
        next_st.cudone = st.conv_sel[BIT_USER_SINGLE] && st.cuix == 2'h3;
      end
      next_st.itog = ~st.itog;
      next_st.ipn = ipn_nx[30:0];
      next_st.iramp = st.iramp + 16'h1;
      if ((icode == IF_UREP) || (icode == IF_USGL && !st.iudone)) begin
        next_st.iuix = st.iuix + 2'h1;
        next_st.iudone = (icode == IF_USGL) && st.iuix == 2'h3;
      end
    end
    // Leaving user mode rearms the single pass
    if (ccode != CV_USER) begin
      next_st.cuix = '0;
      next_st.cudone = 1'b0;
    end
    // A new interface code restarts its sequence from the seed
    next_st.icode = icode;
    if (icode != st.icode) begin
      next_st.ipn = iseed;
      next_st.itog = 1'b0;
      next_st.iramp = '0;
      next_st.iuix = '0;
      next_st.iudone = 1'b0;
    end
    // Register writes
    if (reg_wr) begin
      if (reg_addr == OFS_CFG) begin
        // Soft reset returns every control and generator to reset; the bit never stores
        if (reg_wdata == SOFT_RESET_CODE) begin
          next_st = ST_RESET;
          next_st.rdata = st.rdata;
        end
      end else if (reg_addr == OFS_CONV_SEL) begin
        next_st.conv_sel = reg_wdata;
        if (reg_wdata[BIT_PN_RST_A] || reg_wdata[BIT_PN_RST_B]) begin
          next_st.cpn_l = SEED_PN23[22:0];
          next_st.cpn_s = SEED_PN9[8:0];
        end
      end else if (reg_addr >= OFS_USER_FIRST && reg_addr <= OFS_USER_LAST) begin
        next_st.user[{3'(reg_addr - OFS_USER_FIRST), 3'h0} +: 8] = reg_wdata;
      end else if (reg_addr == OFS_TL_CTRL) begin
        next_st.tl_ctrl = reg_wdata;
      end else if (reg_addr == OFS_IF_CTRL) begin
        next_st.if_ctrl = reg_wdata;
      end else if (reg_addr == OFS_DL_CTRL) begin
        next_st.dl_ctrl = reg_wdata;
      end
    end
  end

  // Register the whole state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_normal_pass: assert property (
    (ccode == CV_OFF && !st.tl_ctrl[BIT_TL_TEST] && icode == IF_OFF)
      |-> fin.data == {PT_SAMPLE, adc_sample, 2'b00})
    else $error("normal mode does not pass samples");
  a_full_scale: assert property (
    (ccode == CV_PFS && !st.tl_ctrl[BIT_TL_TEST] && icode == IF_OFF)
      |-> fin.data == {PT_SAMPLE, W14_PFS, 2'b00})
    else $error("positive full scale word wrong");
  a_checker_alt: assert property (
    (ccode == CV_CHK && push) ##1 (ccode == CV_CHK && !reg_wr)
      |-> conv_word == ($past(conv_word) ^ W14_ONES))
    else $error("checkerboard did not alternate");
  a_pn_reseed: assert property (
    (reg_wr && reg_addr == OFS_CONV_SEL && reg_wdata[BIT_PN_RST_A])
      |=> st.cpn_l == SEED_PN23[22:0] && st.cpn_s == SEED_PN9[8:0])
    else $error("PN generators not reseeded");
  a_ramp_step: assert property (
    (ccode == CV_RAMP && push && !reg_wr) ##1 (ccode == CV_RAMP)
      |-> conv_word == $past(conv_word) + 14'h1)
    else $error("converter ramp did not step");
  a_soft_clear: assert property (
    (reg_wr && reg_addr == OFS_CFG && reg_wdata == SOFT_RESET_CODE)
      |=> st.conv_sel == '0 && st.if_ctrl == '0 && st.tl_ctrl == '0)
    else $error("soft reset left controls set");
  a_tl_raw: assert property (
    (st.tl_ctrl[BIT_TL_TEST] && icode == IF_OFF) |-> fin.data[15:2] == adc_sample)
    else $error("transport test not raw samples");
  a_single_zero: assert property (
    (icode == IF_USGL && st.iudone) |-> fin.data[15:0] == '0)
    else $error("single user pass not zero");
  a_octet_width: assert property (
    (icode != IF_OFF && ipt == PT_SCR8) |-> fin.data[15:8] == '0)
    else $error("octet injection too wide");

  c_pn_long: cover property (ccode == CV_PNL && push ##1 push);
  c_user_done: cover property (ccode == CV_USER && st.cudone);
  c_phy_ramp: cover property (icode == IF_RAMP && ipt == PT_PHY10 && push);
  c_fifo_full: cover property (adc_valid && !adc_ready);
endmodule

// ---- logic/atpg_pkg.sv ----
// Constants shared by the converter test pattern generator
package atpg_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [11:0] OFS_CFG = 12'h000;
  localparam logic [11:0] OFS_CONV_SEL = 12'h550;
  localparam logic [11:0] OFS_USER_FIRST = 12'h551;
  localparam logic [11:0] OFS_USER_LAST = 12'h558;
  localparam logic [11:0] OFS_TL_CTRL = 12'h571;
  localparam logic [11:0] OFS_IF_CTRL = 12'h573;
  localparam logic [11:0] OFS_DL_CTRL = 12'h574;
  // ----------------------------------------
  // Field positions and values
  // ----------------------------------------
  localparam logic [7:0] SOFT_RESET_CODE = 8'h81;
  localparam int BIT_PN_RST_A = 4;
  localparam int BIT_PN_RST_B = 5;
  localparam int BIT_USER_SINGLE = 7;
  localparam int BIT_TL_TEST = 5;
  localparam logic [1:0] PT_SAMPLE = 2'h0;
  localparam logic [1:0] PT_PHY10 = 2'h1;
  localparam logic [1:0] PT_SCR8 = 2'h2;
  // ----------------------------------------
  // Converter pattern codes
  // ----------------------------------------
  localparam logic [3:0] CV_OFF = 4'h0;
  localparam logic [3:0] CV_MID = 4'h1;
  localparam logic [3:0] CV_PFS = 4'h2;
  localparam logic [3:0] CV_NFS = 4'h3;
  localparam logic [3:0] CV_CHK = 4'h4;
  localparam logic [3:0] CV_PNL = 4'h5;
  localparam logic [3:0] CV_PNS = 4'h6;
  localparam logic [3:0] CV_TOG = 4'h7;
  localparam logic [3:0] CV_USER = 4'h8;
  localparam logic [3:0] CV_RAMP = 4'hF;
  // ----------------------------------------
  // Interface pattern codes
  // ----------------------------------------
  localparam logic [3:0] IF_OFF = 4'h0;
  localparam logic [3:0] IF_CHK = 4'h1;
  localparam logic [3:0] IF_TOG = 4'h2;
  localparam logic [3:0] IF_PN31 = 4'h3;
  localparam logic [3:0] IF_PN23 = 4'h4;
  localparam logic [3:0] IF_PN15 = 4'h5;
  localparam logic [3:0] IF_PN9 = 4'h6;
  localparam logic [3:0] IF_PN7 = 4'h7;
  localparam logic [3:0] IF_RAMP = 4'h8;
  localparam logic [3:0] IF_UREP = 4'hE;
  localparam logic [3:0] IF_USGL = 4'hF;
  // ----------------------------------------
  // Seeds and fixed words
  // ----------------------------------------
  localparam logic [30:0] SEED_PN31 = 31'h0003AFFF;
  localparam logic [30:0] SEED_PN23 = 31'h00003AFF;
  localparam logic [30:0] SEED_PN15 = 31'h000003AF;
  localparam logic [30:0] SEED_PN9 = 31'h00000092;
  localparam logic [30:0] SEED_PN7 = 31'h00000007;
  localparam logic [13:0] W14_PFS = 14'h1FFF;
  localparam logic [13:0] W14_NFS = 14'h2000;
  localparam logic [13:0] W14_CHK_A = 14'h1555;
  localparam logic [13:0] W14_CHK_B = 14'h2AAA;
  localparam logic [13:0] W14_ONES = 14'h3FFF;
  localparam logic [15:0] W16_CHK_A = 16'h5555;
  localparam logic [15:0] W16_CHK_B = 16'hAAAA;
  localparam logic [15:0] W16_ONES = 16'hFFFF;
  localparam int FIFO_DEPTH = 8;
  localparam int OUT_W = 18;
endpackage

// ---- logic/atpg_stream_if.sv ----
// Valid/ready word stream between the generator and its buffer
`timescale 1ns/1ps
interface atpg_stream_if #(parameter int W = 18);
  logic valid; // Word offered
  logic ready; // Word accepted
  logic [W-1:0] data; // Word content
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ---- logic/atpg_fifo.sv ----
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module atpg_fifo #(
  parameter int W = 18,
  parameter int D = 8
) (
  input wire logic clk,
  input wire logic rstn,
  atpg_stream_if.snk wr,
  atpg_stream_if.src rd
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem; // Storage
    logic [AW-1:0] wp; // Write pointer
    logic [AW-1:0] rp; // Read pointer
    logic [AW:0] cnt; // Fill level
  } atpg_fifo_s;
  atpg_fifo_s st;
  atpg_fifo_s next_st;
  logic push;
  logic pop;

  // Full and empty straight from the level, so back-pressure is exact
  assign wr.ready = (st.cnt != (AW+1)'(D));
  assign rd.valid = (st.cnt != '0);
  assign rd.data = st.mem[st.rp];
  assign push = wr.valid && wr.ready;
  assign pop = rd.valid && rd.ready;

  // Pointer and level update
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wp] = wr.data;
      next_st.wp = (st.wp == AW'(D-1)) ? '0 : st.wp + AW'(1);
    end
    if (pop) begin
      next_st.rp = (st.rp == AW'(D-1)) ? '0 : st.rp + AW'(1);
    end
    next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  // Register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule

// ---- test/atpg_rx_model.sv ----
// Receiver-side model that takes generated words at a chosen pace
`timescale 1ns/1ps
module atpg_rx_model (
  input wire logic clk,
  input wire logic [1:0] pace,
  input wire logic [1:0] out_point,
  input wire logic [15:0] out_word,
  input wire logic out_valid,
  output logic out_ready
);
  // ----------------------------------------
  // Accept side
  // ----------------------------------------
  logic [17:0] q[$]; // Received point and word, oldest first
  logic ph = 1'b0; // Half-rate phase for the slow pace
  // Ready moves off the sampling edge; valid does not depend on ready,
  // so a word is logged here exactly when the next edge pops it
  always @(negedge clk) begin
    ph = ~ph;
    // Pace 0 prompt, 1 every other cycle, 2 stalled
    out_ready = (pace == 2'h0) || (pace == 2'h1 && ph);
    if (out_valid === 1'b1 && out_ready) begin
      q.push_back({out_point, out_word});
    end
  end
endmodule

// ---- test/adc_output_test_pattern_gen_tb.sv ----
// Self-checking bench for the test pattern generator
`timescale 1ns/1ps
module adc_output_test_pattern_gen_tb;
  import atpg_pkg::*;
  // ----------------------------------------
  // Stimulus and bookkeeping
  // ----------------------------------------
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [13:0] adc_sample = 14'h0000;
  logic adc_valid = 1'b0;
  logic adc_ready;
  logic [1:0] out_point;
  logic [15:0] out_word;
  logic out_valid;
  logic out_ready;
  logic [1:0] pace = 2'h0; // Receiver pace
  int mismatches = 0;
  int cmp_count = 0;
  logic [30:0] lf; // Reference shift register for PN words
  logic [15:0] up [4] = '{16'h1234, 16'hABCD, 16'h0F0F, 16'hF00D}; // User words
  logic [15:0] w;
  logic [15:0] m;
  int sh;
  int n;
  int lens [5] = '{31, 23, 15, 9, 7};
  int taps [5] = '{28, 18, 14, 5, 6};
  logic [30:0] seeds [5] = '{SEED_PN31, SEED_PN23, SEED_PN15, SEED_PN9, SEED_PN7};
  logic [3:0] ifc [5] = '{IF_CHK, IF_TOG, IF_RAMP, IF_UREP, IF_USGL};
  always #2.5 clk = ~clk;
  atpg_gen uut (.clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .adc_sample(adc_sample), .adc_valid(adc_valid), .adc_ready(adc_ready),
    .out_point(out_point), .out_word(out_word), .out_valid(out_valid),
    .out_ready(out_ready));
  atpg_rx_model rx (.clk(clk), .pace(pace), .out_point(out_point), .out_word(out_word),
    .out_valid(out_valid), .out_ready(out_ready));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  // Verdict and end of run, shared with the watchdog
  task test_done;
    if (mismatches == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task cmp8(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t byte %h expected %h", $time, g, e);
    end
  endtask
  // Waits a bounded time for the receiver, then checks point and word
  task cmpw(input logic [1:0] pt, input logic [15:0] e);
    logic [17:0] g;
    g = 'x;
    for (int k = 0; k < 100 && rx.q.size() == 0; k++) @(negedge clk);
    if (rx.q.size() != 0) g = rx.q.pop_front();
    cmp_count++;
    if (g !== {pt, e}) begin
      mismatches++;
      $display("[ERR] %0t word %h expected %h", $time, g, {pt, e});
    end
  endtask
  // One-cycle strobes; each call starts on a fresh falling edge
  task wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task rdc(input logic [11:0] a, input logic [7:0] e);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    cmp8(reg_rdata, e);
  endtask
  // Sample held until the edge that sees ready high
  task send(input logic [13:0] s);
    @(negedge clk);
    adc_sample = s;
    adc_valid = 1'b1;
    for (int k = 0; k < 100 && adc_ready !== 1'b1; k++) @(negedge clk);
    @(negedge clk);
    adc_valid = 1'b0;
  endtask
  task sc(input logic [13:0] s, input logic [1:0] pt, input logic [15:0] e);
    send(s);
    cmpw(pt, e);
  endtask
  // Soft reset, user words, then both selectors
  task mode(input logic [7:0] c, input logic [7:0] i);
    wr(OFS_CFG, SOFT_RESET_CODE);
    for (int k = 0; k < 4; k++) begin
      wr(OFS_USER_FIRST + 12'(2 * k), up[k][7:0]);
      wr(OFS_USER_FIRST + 12'(2 * k + 1), up[k][15:8]);
    end
    wr(OFS_CONV_SEL, c);
    wr(OFS_IF_CTRL, i);
  endtask
  // Next PN word: nb bits shifted in, first one ends up highest
  task pn_w(input int len, input int tap, input int nb, output logic [15:0] o);
    logic b;
    o = 16'h0000;
    for (int k = 0; k < nb; k++) begin
      b = lf[len-1] ^ lf[tap-1];
      lf = {lf[29:0], b};
      o = {o[14:0], b};
    end
  endtask
  // ----------------------------------------
  // Watchdog, 30k cycles, well beyond the expected run
  // ----------------------------------------
  initial begin
    #150000;
    mismatches++;
    test_done();
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    rdc(OFS_CONV_SEL, 8'h00);
    rdc(OFS_IF_CTRL, 8'h00);
    wr(OFS_DL_CTRL, 8'h05);
    rdc(OFS_DL_CTRL, 8'h05);
    wr(12'h123, 8'hFF);
    rdc(12'h123, 8'h00);
    mode(8'h00, 8'h00);
    sc(14'h2ABC, PT_SAMPLE, {14'h2ABC, 2'b00});
    // Fixed words must ignore the sample value
    mode(CV_MID, 8'h00);
    sc(14'h1234, PT_SAMPLE, 16'h0000);
    mode(CV_PFS, 8'h00);
    sc(14'h0F0F, PT_SAMPLE, {W14_PFS, 2'b00});
    mode(CV_NFS, 8'h00);
    sc(14'h3333, PT_SAMPLE, {W14_NFS, 2'b00});
    mode(CV_CHK, 8'h00);
    for (int i = 0; i < 3; i++) sc(14'(i), PT_SAMPLE, i[0] ? 16'hAAA8 : 16'h5554);
    mode(CV_TOG, 8'h00);
    for (int i = 0; i < 3; i++) sc(14'h0, PT_SAMPLE, i[0] ? 16'hFFFC : 16'h0000);
    mode(CV_RAMP, 8'h00);
    for (int i = 0; i < 5; i++) sc(14'h2000, PT_SAMPLE, {14'(i), 2'b00});
    lf = SEED_PN23;
    mode(CV_PNL, 8'h00);
    for (int i = 0; i < 3; i++) begin
      pn_w(23, 18, 14, w);
      sc(14'h0, PT_SAMPLE, {w[13:0], 2'b00});
    end
    // Either reset bit restarts the short sequence from its seed
    for (int b = BIT_PN_RST_A; b <= BIT_PN_RST_B; b++) begin
      lf = SEED_PN9;
      mode(CV_PNS, 8'h00);
      for (int i = 0; i < 2; i++) begin
        pn_w(9, 5, 14, w);
        sc(14'h0, PT_SAMPLE, {w[13:0], 2'b00});
      end
      wr(OFS_CONV_SEL, CV_PNS | 8'(1 << b));
      lf = SEED_PN9;
      pn_w(9, 5, 14, w);
      sc(14'h0, PT_SAMPLE, {w[13:0], 2'b00});
    end
    mode(CV_USER, 8'h00);
    for (int i = 0; i < 6; i++) sc(14'h0, PT_SAMPLE, up[i%4] & 16'hFFFC);
    mode(CV_USER | 8'h80, 8'h00);
    for (int i = 0; i < 6; i++) sc(14'h0, PT_SAMPLE, i < 4 ? up[i%4] & 16'hFFFC : 16'h0);
    mode(CV_CHK, 8'h00);
    wr(OFS_TL_CTRL, 8'h20);
    sc(14'h0777, PT_SAMPLE, {14'h0777, 2'b00});
    // Interface patterns at each injection point, slow receiver
    pace = 2'h1;
    for (int p = 0; p < 3; p++) begin
      m = (p == 0) ? 16'hFFFF : (p == 1) ? 16'h03FF : 16'h00FF;
      sh = (p == 0) ? 0 : (p == 1) ? 6 : 8;
      for (int c = 0; c < 5; c++) begin
        mode(8'h00, {2'b00, 2'(p), ifc[c]});
        n = (ifc[c] == IF_RAMP && p == 2) ? 258 : 6;
        for (int i = 0; i < n; i++) begin
          case (ifc[c])
            IF_CHK: w = (i[0] ? 16'hAAAA : 16'h5555) & m;
            IF_TOG: w = (i[0] ? 16'hFFFF : 16'h0000) & m;
            IF_RAMP: w = 16'(i) & m;
            IF_UREP: w = up[i%4] >> sh;
            default: w = (i < 4) ? up[i%4] >> sh : 16'h0000;
          endcase
          sc(14'h1111, 2'(p), w);
        end
      end
      for (int j = 0; j < 5; j++) begin
        lf = seeds[j];
        mode(8'h00, {2'b00, 2'(p), 4'(3 + j)});
        for (int i = 0; i < 3; i++) begin
          pn_w(lens[j], taps[j], (p == 0) ? 16 : (p == 1) ? 10 : 8, w);
          sc(14'h0, 2'(p), w);
        end
      end
    end
    pace = 2'h0;
    // Return to normal mode by soft reset
    wr(OFS_IF_CTRL, 8'h21);
    wr(OFS_CFG, SOFT_RESET_CODE);
    rdc(OFS_CFG, 8'h00);
    rdc(OFS_IF_CTRL, 8'h00);
    sc(14'h0123, PT_SAMPLE, {14'h0123, 2'b00});
    wr(OFS_CONV_SEL, 8'h05);
    wr(OFS_CFG, 8'h01);
    rdc(OFS_CONV_SEL, 8'h05);
    // Fill the buffer with the receiver stalled, then drain slowly
    mode(8'h00, 8'h00);
    pace = 2'h2;
    for (int i = 0; i < FIFO_DEPTH; i++) send(14'(i + 5));
    cmp8({7'h00, adc_ready}, 8'h00);
    pace = 2'h1;
    for (int i = 0; i < FIFO_DEPTH; i++) cmpw(PT_SAMPLE, {14'(i + 5), 2'b00});
    // Last word is logged one edge before the buffer pops it
    @(negedge clk);
    cmp8({7'h00, out_valid}, 8'h00);
    test_done();
  end
endmodule
